/* File: dacr_ctl.sv */
// converter mode, configuration and result registers for two SAR converters
// assumes: SFR strobes, start and raw samples are synchronous to CORE_CLK
//
// What this block does
// - differential select bit: 0 two single-ended converters, 1 one differential.
// - single-ended: each converter's result lands in its own high/low bytes.
// - differential: combined result in first converter bytes, two's complement.
// - differential: second converter's single-ended result still stored in its bytes.
// - each result word is 16 bits, split into high and low bytes.
// - conversion clock is system clock divided by divider field plus one.
// - busy falling sets the done flag and raises interrupt when enabled.
`timescale 1ns/10ps
`default_nettype none
`include "dacr_defines.svh"
module dacr_ctl #(
  parameter logic [7:0] CAL_TICKS = `DACR_CAL_TICKS
) (
  input  wire logic        CORE_CLK,
  input  wire logic        ARST_N,
  input  wire logic [7:0]  SFR_ADDR,
  input  wire logic        SFR_WE,
  input  wire logic        SFR_RE,
  input  wire logic [7:0]  SFR_WDATA,
  output var  logic [7:0]  SFR_RDATA,
  input  wire logic        CONV_START,
  input  wire logic [15:0] FIRST_SAMPLE,
  input  wire logic [15:0] SECOND_SAMPLE,
  input  wire logic        DONE_CLEAR,
  input  wire logic        IRQ_ENABLE,
  output var  logic        CONVERSION_IN_PROGRESS,
  output var  logic        CONVERSION_DONE_FLAG,
  output var  logic        CONVERSION_IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // divider instance
  dacr_clk_if clk_link ();

  dacr_clk_div u_div (
    .clk    (CORE_CLK),
    .arst_n (ARST_N),
    .link   (clk_link.gen)
  );

  dacr_pkg::dacr_ctl_s st_reg;
  dacr_pkg::dacr_ctl_s st_next;

  logic               wr_mode;
  logic               wr_cfg;
  logic               finish;
  logic               cal_end;
  logic signed [16:0] diff_full;
  logic [2:0]         cal_req;

  // register address match
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] want);
    hit = (addr == want);
  endfunction : hit

  assign wr_mode   = SFR_WE && hit(SFR_ADDR, `DACR_ADDR_INPUT_MODE);
  assign wr_cfg    = SFR_WE && hit(SFR_ADDR, `DACR_ADDR_CONV_CONFIG);
  assign cal_req   = SFR_WDATA[`DACR_BIT_GAIN_CAL:`DACR_BIT_OFS_CAL];
  assign finish    = (st_reg.state == dacr_pkg::ST_CONVERT) && clk_link.tick
                     && (st_reg.count == `DACR_CONV_TICKS - 8'h01);
  assign cal_end   = (st_reg.state == dacr_pkg::ST_CALIBRATE) && clk_link.tick
                     && (st_reg.count == CAL_TICKS - 8'h01);
  // full 17-bit signed difference, halved to fit 16 bits when stored
  assign diff_full = $signed({1'b0, FIRST_SAMPLE}) - $signed({1'b0, SECOND_SAMPLE});

  assign clk_link.divider = st_reg.divider;
  assign clk_link.run     = (st_reg.state != dacr_pkg::ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next = st_reg;
    if (wr_mode) begin
      st_next.diff_mode = SFR_WDATA[`DACR_BIT_DIFF_SELECT];
    end
    if (wr_cfg) begin
      st_next.divider    = SFR_WDATA[7:`DACR_BIT_DIV_LSB];
      st_next.src_select = SFR_WDATA[`DACR_BIT_SRC_SELECT];
    end
    case (st_reg.state)
      dacr_pkg::ST_IDLE: begin
        st_next.count = 8'h00;
        if (wr_cfg && (cal_req != 3'b000)) begin
          st_next.cal_run = cal_req;
          st_next.state   = dacr_pkg::ST_CALIBRATE;
        end else if (CONV_START) begin
          st_next.busy  = 1'b1;
          st_next.state = dacr_pkg::ST_CONVERT;
        end
      end
      dacr_pkg::ST_CONVERT: begin
        if (finish) begin
          st_next.state = dacr_pkg::ST_IDLE;
          st_next.busy  = 1'b0;
          if (st_reg.diff_mode) begin
            st_next.first_result = diff_full[16:1];
          end else begin
            st_next.first_result = FIRST_SAMPLE;
          end
          // second result kept in both modes
          st_next.second_result = SECOND_SAMPLE;
        end else if (clk_link.tick) begin
          st_next.count = st_reg.count + 8'h01;
        end
      end
      dacr_pkg::ST_CALIBRATE: begin
        if (cal_end) begin
          st_next.state   = dacr_pkg::ST_IDLE;
          st_next.cal_run = 3'b000;
        end else if (clk_link.tick) begin
          st_next.count = st_reg.count + 8'h01;
        end
      end
      default: begin
        st_next.state = dacr_pkg::ST_IDLE;
      end
    endcase
    // busy fall sets flag, set wins over clear
    st_next.done = (st_reg.done && !DONE_CLEAR) || finish;
    st_next.irq  = st_next.done && IRQ_ENABLE;
    st_next.rdata = st_reg.rdata;
    if (SFR_RE) begin
      case (SFR_ADDR)
        `DACR_ADDR_INPUT_MODE:  st_next.rdata = {1'b0, st_reg.diff_mode, 6'h00};
        `DACR_ADDR_CONV_CONFIG: st_next.rdata = {st_reg.divider, st_reg.src_select, st_reg.cal_run};
        `DACR_ADDR_FIRST_LOW:   st_next.rdata = st_reg.first_result[7:0];
        `DACR_ADDR_FIRST_HIGH:  st_next.rdata = st_reg.first_result[15:8];
        `DACR_ADDR_SECOND_LOW:  st_next.rdata = st_reg.second_result[7:0];
        `DACR_ADDR_SECOND_HIGH: st_next.rdata = st_reg.second_result[15:8];
        `DACR_ADDR_STATUS:      st_next.rdata = {6'h00, st_reg.done, st_reg.busy};
        default:                st_next.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_reg         <= '0;
      st_reg.state   <= dacr_pkg::ST_IDLE;
      st_reg.divider <= 4'hf;
    end else begin
      st_reg <= st_next;
    end
  end

  assign SFR_RDATA              = st_reg.rdata;
  assign CONVERSION_IN_PROGRESS = st_reg.busy;
  assign CONVERSION_DONE_FLAG   = st_reg.done;
  assign CONVERSION_IRQ         = st_reg.irq;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!ARST_N);

  // helper: cycles since last divider tick
  logic [4:0] gap_cnt;
  logic       gap_seen;
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gap_cnt  <= 5'h00;
      gap_seen <= 1'b0;
    end else if (!clk_link.run) begin
      gap_cnt  <= 5'h00;
      gap_seen <= 1'b0;
    end else if (clk_link.tick) begin
      gap_cnt  <= 5'h01;
      gap_seen <= 1'b1;
    end else begin
      gap_cnt  <= gap_cnt + 5'h01;
    end
  end

  sequence seq_start_idle;
    CONV_START && (st_reg.state == dacr_pkg::ST_IDLE) && !wr_cfg;
  endsequence
  sequence seq_busy_rises;
    ##1 CONVERSION_IN_PROGRESS;
  endsequence

  chk_mode_write: assert property (wr_mode |=> st_reg.diff_mode == $past(SFR_WDATA[6]))
    else $error("mode bit not taken from write");
  chk_single_place: assert property (finish && !st_reg.diff_mode |=> st_reg.first_result == $past(FIRST_SAMPLE))
    else $error("single-ended result misplaced");
  chk_diff_place: assert property (finish && st_reg.diff_mode |=>
    st_reg.first_result == 16'($past({1'b0, FIRST_SAMPLE} - {1'b0, SECOND_SAMPLE}) >> 1))
    else $error("differential result wrong");
  chk_second_kept: assert property (finish |=> st_reg.second_result == $past(SECOND_SAMPLE))
    else $error("second result not stored");
  chk_high_byte: assert property (SFR_RE && SFR_ADDR == 8'hbe |=> SFR_RDATA == $past(st_reg.first_result[15:8]))
    else $error("high byte readback wrong");
  chk_tick_gap: assert property (clk_link.tick && gap_seen && $stable(st_reg.divider) |->
    gap_cnt == {1'b0, st_reg.divider} + 5'h01)
    else $error("conversion clock spacing wrong");
  chk_done_fall: assert property ($fell(CONVERSION_IN_PROGRESS) |-> CONVERSION_DONE_FLAG ##1 (CONVERSION_IRQ == $past(IRQ_ENABLE)))
    else $error("done flag or irq missing after busy fall");
  chk_conv_start: assert property (seq_start_idle |-> seq_busy_rises)
    else $error("start did not raise busy");
  chk_cal_idle: assert property (wr_cfg && (cal_req != 3'b000) && !cal_end
    && (st_reg.state != dacr_pkg::ST_IDLE) |=> st_reg.cal_run == $past(st_reg.cal_run))
    else $error("calibration started while busy");
  chk_cal_reads: assert property (wr_cfg && (cal_req != 3'b000) && st_reg.state == dacr_pkg::ST_IDLE |=>
    st_reg.cal_run == $past(cal_req) && st_reg.state == dacr_pkg::ST_CALIBRATE)
    else $error("calibration bits not running");
  chk_cal_end: assert property (cal_end |=> st_reg.cal_run == 3'b000 && st_reg.state == dacr_pkg::ST_IDLE)
    else $error("calibration did not end");
  chk_done_clear: assert property (DONE_CLEAR && !finish |=> !CONVERSION_DONE_FLAG)
    else $error("done flag not cleared");
  chk_set_wins: assert property (finish |=> CONVERSION_DONE_FLAG)
    else $error("done flag not set at finish");
  chk_irq_follow: assert property (1'b1 |=> CONVERSION_IRQ == (CONVERSION_DONE_FLAG && $past(IRQ_ENABLE)))
    else $error("interrupt does not follow done flag");

endmodule : dacr_ctl
`default_nettype wire

/* File: dacr_defines.svh */
// register map, field positions, reset values and timing counts
// assumes: included by bare name from the control module and the testbench
`ifndef DACR_DEFINES_SVH
`define DACR_DEFINES_SVH

// special-function-register addresses
`define DACR_ADDR_INPUT_MODE     8'hbb
`define DACR_ADDR_CONV_CONFIG    8'hbc
`define DACR_ADDR_FIRST_LOW      8'hbd
`define DACR_ADDR_FIRST_HIGH     8'hbe
`define DACR_ADDR_SECOND_LOW     8'hc1
`define DACR_ADDR_SECOND_HIGH    8'hc2
`define DACR_ADDR_STATUS         8'hc3

// field positions
`define DACR_BIT_DIFF_SELECT     6
`define DACR_BIT_DIV_LSB         4
`define DACR_BIT_SRC_SELECT      3
`define DACR_BIT_GAIN_CAL        2
`define DACR_BIT_LIN_CAL         1
`define DACR_BIT_OFS_CAL         0

// reset values
`define DACR_RST_INPUT_MODE      8'h00
`define DACR_RST_CONV_CONFIG     8'hf0

// conversion clocks per conversion and per calibration
`define DACR_CONV_TICKS          8'h10
`define DACR_CAL_TICKS           8'h40

`endif

/* File: dacr_pkg.sv */
// types shared by the converter control modules
// assumes: dacr_defines.svh is on the include path
`default_nettype none
package dacr_pkg;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CONVERT,
    ST_CALIBRATE
  } dacr_state_e;

  typedef struct packed {
    dacr_state_e state;
    logic        diff_mode;
    logic [3:0]  divider;
    logic        src_select;
    logic [2:0]  cal_run;
    logic [7:0]  count;
    logic [15:0] first_result;
    logic [15:0] second_result;
    logic        busy;
    logic        done;
    logic        irq;
    logic [7:0]  rdata;
  } dacr_ctl_s;

  typedef struct packed {
    logic [3:0] count;
    logic       tick;
  } dacr_div_s;

endpackage : dacr_pkg
`default_nettype wire

/* File: dacr_clk_if.sv */
// link between the control block and its conversion clock divider
// assumes: both ends run on the same system clock
`timescale 1ns/10ps
`default_nettype none
interface dacr_clk_if;
  logic [3:0] divider;
  logic       run;
  logic       tick;
  modport ctl (output divider, output run, input tick);
  modport gen (input divider, input run, output tick);
endinterface : dacr_clk_if
`default_nettype wire

/* File: dacr_clk_div.sv */
// conversion clock enable: one pulse every divider+1 system clocks
// assumes: divider and run come from logic on the same clock
`timescale 1ns/10ps
`default_nettype none
module dacr_clk_div (
  input  wire logic   clk,
  input  wire logic   arst_n,
  dacr_clk_if.gen     link
);
  dacr_pkg::dacr_div_s st_reg;
  dacr_pkg::dacr_div_s st_next;

  // count up system clocks while running, pulse at terminal count
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (!link.run) begin
      st_next.count = 4'h0;
    end else if (st_reg.count >= link.divider) begin
      st_next.count = 4'h0;
      st_next.tick  = 1'b1;
    end else begin
      st_next.count = st_reg.count + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.tick = st_reg.tick;
endmodule : dacr_clk_div
`default_nettype wire

/* File: dacr_tb.sv */
// self-checking bench for the converter mode, configuration and result registers
// assumes: dacr_pkg and dacr_defines.svh compiled ahead, assertions live in the design
`timescale 1ns/10ps
`default_nettype none
`include "dacr_defines.svh"
module testbench;
  logic        CORE_CLK      = 1'b0;
  logic        ARST_N        = 1'b0;
  logic [7:0]  SFR_ADDR      = 8'h00;
  logic        SFR_WE        = 1'b0;
  logic        SFR_RE        = 1'b0;
  logic [7:0]  SFR_WDATA     = 8'h00;
  logic [7:0]  SFR_RDATA;
  logic        CONV_START    = 1'b0;
  logic [15:0] FIRST_SAMPLE  = 16'h0000;
  logic [15:0] SECOND_SAMPLE = 16'h0000;
  logic        DONE_CLEAR    = 1'b0;
  logic        IRQ_ENABLE    = 1'b0;
  logic        busy;
  logic        done;
  logic        irq;
  int          error_cnt     = 0;
  int          cmp_count     = 0;
  logic [7:0]  rd;

  // 250 MHz system clock
  always #2 CORE_CLK = ~CORE_CLK;

  dacr_ctl #(.CAL_TICKS(8'h02)) dacr_ctl_i (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .SFR_ADDR(SFR_ADDR), .SFR_WE(SFR_WE), .SFR_RE(SFR_RE),
    .SFR_WDATA(SFR_WDATA), .SFR_RDATA(SFR_RDATA), .CONV_START(CONV_START), .FIRST_SAMPLE(FIRST_SAMPLE),
    .SECOND_SAMPLE(SECOND_SAMPLE), .DONE_CLEAR(DONE_CLEAR), .IRQ_ENABLE(IRQ_ENABLE),
    .CONVERSION_IN_PROGRESS(busy), .CONVERSION_DONE_FLAG(done), .CONVERSION_IRQ(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // closing report and compares
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_of_test

  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp8

  task automatic cmp1(input string what, input logic exp, input logic got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp1

  task automatic cmp_len(input string what, input int exp, input int got);
    cmp_count++;
    if (got != exp) begin
      error_cnt++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : cmp_len

  ////////////////////////////////////////////////////////////////////////////////
  // register bus cycles, one-cycle strobes driven on the falling edge
  task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge CORE_CLK);
    SFR_ADDR  = addr;
    SFR_WDATA = data;
    SFR_WE    = 1'b1;
    @(negedge CORE_CLK);
    SFR_WE    = 1'b0;
  endtask : sfr_write

  task automatic sfr_read(input logic [7:0] addr, output logic [7:0] data);
    @(negedge CORE_CLK);
    SFR_ADDR = addr;
    SFR_RE   = 1'b1;
    @(negedge CORE_CLK);
    SFR_RE   = 1'b0;
    @(negedge CORE_CLK);
    data     = SFR_RDATA;
  endtask : sfr_read

  // one conversion, busy length counted in system clocks
  task automatic convert(input int exp_len);
    int n;
    n = 0;
    @(negedge CORE_CLK);
    CONV_START = 1'b1;
    @(negedge CORE_CLK);
    CONV_START = 1'b0;
    while (busy === 1'b1 && n < 2000) begin
      n++;
      @(negedge CORE_CLK);
    end
    if (n >= 2000) begin
      error_cnt++;
      end_of_test();
    end
    cmp_len("busy length", exp_len, n);
  endtask : convert

  ////////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic reset_values();
    sfr_read(`DACR_ADDR_INPUT_MODE, rd);
    cmp8("input mode reset", `DACR_RST_INPUT_MODE, rd);
    sfr_read(`DACR_ADDR_CONV_CONFIG, rd);
    cmp8("config reset", `DACR_RST_CONV_CONFIG, rd);
    sfr_read(8'h10, rd);
    cmp8("unmapped read", 8'h00, rd);
  endtask : reset_values

  task automatic single_ended();
    FIRST_SAMPLE  = 16'h1234;
    SECOND_SAMPLE = 16'habcd;
    IRQ_ENABLE    = 1'b1;
    // busy spans the start cycle plus sixteen conversion clocks of sixteen system clocks
    convert(`DACR_CONV_TICKS * 16 + 1);
    cmp1("done flag", 1'b1, done);
    @(negedge CORE_CLK);
    cmp1("irq", 1'b1, irq);
    sfr_read(`DACR_ADDR_STATUS, rd);
    cmp8("status done", 8'h02, rd);
    sfr_read(`DACR_ADDR_FIRST_HIGH, rd);
    cmp8("first high", 8'h12, rd);
    sfr_read(`DACR_ADDR_FIRST_LOW, rd);
    cmp8("first low", 8'h34, rd);
    sfr_read(`DACR_ADDR_SECOND_HIGH, rd);
    cmp8("second high", 8'hab, rd);
    sfr_read(`DACR_ADDR_SECOND_LOW, rd);
    cmp8("second low", 8'hcd, rd);
    @(negedge CORE_CLK);
    DONE_CLEAR = 1'b1;
    @(negedge CORE_CLK);
    DONE_CLEAR = 1'b0;
    @(negedge CORE_CLK);
    cmp1("done cleared", 1'b0, done);
    cmp1("irq cleared", 1'b0, irq);
  endtask : single_ended

  task automatic differential();
    IRQ_ENABLE = 1'b0;
    sfr_write(`DACR_ADDR_INPUT_MODE, 8'h40);
    sfr_read(`DACR_ADDR_INPUT_MODE, rd);
    cmp8("input mode", 8'h40, rd);
    sfr_write(`DACR_ADDR_CONV_CONFIG, 8'h08);
    sfr_read(`DACR_ADDR_CONV_CONFIG, rd);
    cmp8("config source bit", 8'h08, rd);
    FIRST_SAMPLE  = 16'h1000;
    SECOND_SAMPLE = 16'h3000;
    // clear held over the finishing edge: the set must win
    DONE_CLEAR    = 1'b1;
    convert(`DACR_CONV_TICKS * 1 + 1);
    DONE_CLEAR    = 1'b0;
    cmp1("done set wins", 1'b1, done);
    // difference of -0x2000 halved gives -0x1000
    sfr_read(`DACR_ADDR_FIRST_HIGH, rd);
    cmp8("diff high", 8'hf0, rd);
    sfr_read(`DACR_ADDR_FIRST_LOW, rd);
    cmp8("diff low", 8'h00, rd);
    sfr_read(`DACR_ADDR_SECOND_HIGH, rd);
    cmp8("second raw high", 8'h30, rd);
    @(negedge CORE_CLK);
    cmp1("irq masked", 1'b0, irq);
    sfr_write(`DACR_ADDR_INPUT_MODE, 8'h00);
  endtask : differential

  task automatic calibration();
    sfr_write(`DACR_ADDR_CONV_CONFIG, 8'hf4);
    sfr_read(`DACR_ADDR_CONV_CONFIG, rd);
    cmp8("gain cal running", 8'hf4, rd);
    // a second trigger while running is ignored
    sfr_write(`DACR_ADDR_CONV_CONFIG, 8'hf3);
    repeat (40) @(negedge CORE_CLK);
    sfr_read(`DACR_ADDR_CONV_CONFIG, rd);
    cmp8("cal finished", 8'hf0, rd);
    sfr_write(`DACR_ADDR_CONV_CONFIG, 8'hf3);
    sfr_read(`DACR_ADDR_CONV_CONFIG, rd);
    cmp8("two cals running", 8'hf3, rd);
    repeat (40) @(negedge CORE_CLK);
    // calibration bits written during a conversion are ignored
    @(negedge CORE_CLK);
    CONV_START = 1'b1;
    @(negedge CORE_CLK);
    CONV_START = 1'b0;
    sfr_write(`DACR_ADDR_CONV_CONFIG, 8'hf7);
    sfr_read(`DACR_ADDR_CONV_CONFIG, rd);
    cmp8("cal refused while busy", 8'hf0, rd);
    for (int i = 0; i < 300 && busy === 1'b1; i++) @(negedge CORE_CLK);
    cmp1("busy after refused cal", 1'b0, busy);
  endtask : calibration

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (12) @(negedge CORE_CLK);
    ARST_N = 1'b1;
    reset_values();
    single_ended();
    differential();
    calibration();
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
